// File: flash_sp_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_sp_map.svh"
module flash_sp_device
   import flash_sp_pkg::*;
#(
   parameter int PAGE_WORDS_LOG2 = 7,
   parameter int PAGES_LOG2      = 9,
   parameter int HALT_PAGE_FIRST = 480,
   parameter int BOOT_ADDR       = 16'hF000,
   parameter int OP_CYCLES       = `OP_TIME_US * `CLK_MHZ
) (
   input  wire logic  clock,
   input  wire logic  sys_rst,
   input  wire logic  boot_reset_select,
   flash_sp_if.device bus
);
   localparam int PW = PAGE_WORDS_LOG2;
   localparam int PG = PAGES_LOG2;
   logic [15:0]       mem [0:(1<<(PW+PG))-1];
   logic [15:0]       page_buf [0:(1<<PW)-1];
   logic [(1<<PW)-1:0] buf_valid;
   logic [7:0]        csr_reg;
   logic [2:0]        arm_cnt_reg;
   logic [PG-1:0]     page_reg;
   logic [PW-1:0]     word_idx;
   logic [PG-1:0]     page_idx;
   logic [31:0]       op_cnt_reg;
   op_kind_t          op_reg;
   logic [3:0]        lock_reg;
   logic              loading_reg;
   logic              ee_s1, ee_s2;
   logic              strap_done_reg;
   logic [7:0]        rbyte_reg;
   logic              rvalid_reg;
   logic              stall_reg, block_reg, irq_reg;
   logic [15:0]       vec_reg;
   logic              armed, fire, done;

   assign word_idx = bus.pointer[PW:1];
   assign page_idx = bus.pointer[PW+PG:PW+1];
   assign armed    = csr_reg[`CSR_EN_BIT] && op_reg == op_none && arm_cnt_reg != 3'h0;
   assign fire     = armed && bus.store_exec && !ee_s2;
   assign done     = op_reg != op_none && op_cnt_reg == 32'h0;

   // EEPROM busy may come from another block timing; synchronised like a pin
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ee_s1 <= 1'b0;
         ee_s2 <= 1'b0;
      end else begin
         ee_s1 <= bus.eeprom_write_busy;
         ee_s2 <= ee_s1;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         strap_done_reg <= 1'b0;
         vec_reg        <= `APP_RESET_ADDR;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         vec_reg <= boot_reset_select ? `APP_RESET_ADDR : 16'(BOOT_ADDR);
      end
   end

   // Control register; a write while an operation runs is ignored
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         csr_reg     <= 8'h00;
         arm_cnt_reg <= 3'h0;
      end else begin
         if (bus.csr_we && op_reg == op_none && !ee_s2) begin
            csr_reg[`CSR_IE_BIT] <= bus.csr_wdata[`CSR_IE_BIT];
            csr_reg[4:0]         <= bus.csr_wdata[4:0];
            arm_cnt_reg          <= `ARM_WINDOW;
         end else if (fire) begin
            arm_cnt_reg <= 3'h0;
            if (csr_reg[4:0] == `CMD_LOAD || csr_reg[4:0] == `CMD_REEN)
               csr_reg[4:0] <= 5'h00;
         end else if (done) begin
            csr_reg[4:0] <= 5'h00;
         end else if (arm_cnt_reg != 3'h0) begin
            arm_cnt_reg <= arm_cnt_reg - 3'h1;
            if (arm_cnt_reg == 3'h1 && op_reg == op_none)
               csr_reg[4:0] <= 5'h00;
         end
         if (fire && csr_reg[4:0] inside {`CMD_ERASE, `CMD_WRITE})
            csr_reg[`CSR_BUSY_BIT] <= page_idx < PG'(HALT_PAGE_FIRST) || csr_reg[`CSR_BUSY_BIT];
         else if (fire && csr_reg[4:0] == `CMD_REEN && op_reg == op_none)
            csr_reg[`CSR_BUSY_BIT] <= 1'b0;
      end
   end

   // Operation engine; address latched so the pointer is free afterwards
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         op_reg     <= op_none;
         op_cnt_reg <= 32'h0;
         page_reg   <= '0;
         stall_reg  <= 1'b0;
         block_reg  <= 1'b0;
      end else if (fire && csr_reg[4:0] inside {`CMD_ERASE, `CMD_WRITE, `CMD_LOCK}) begin
         op_reg     <= csr_reg[4:0] == `CMD_ERASE ? op_erase :
                       csr_reg[4:0] == `CMD_WRITE ? op_write : op_lock;
         op_cnt_reg <= 32'(OP_CYCLES - 1);
         page_reg   <= page_idx;
         if (csr_reg[4:0] != `CMD_LOCK) begin
            block_reg <= 1'b1;
            stall_reg <= page_idx >= PG'(HALT_PAGE_FIRST);
         end
      end else if (done) begin
         op_reg    <= op_none;
         stall_reg <= 1'b0;
         block_reg <= 1'b0;
      end else if (op_reg != op_none) begin
         op_cnt_reg <= op_cnt_reg - 32'h1;
      end
   end

   // Page buffer and flash array; data pair ignored for erase and write
   always_ff @(posedge clock) begin
      if (fire && csr_reg[4:0] == `CMD_LOAD)
         page_buf[word_idx] <= bus.data_word;
      if (done && op_reg == op_erase)
         for (int i = 0; i < (1<<PW); i++)
            mem[{page_reg, PW'(i)}] <= 16'hFFFF;
      if (done && op_reg == op_write)
         for (int i = 0; i < (1<<PW); i++)
            mem[{page_reg, PW'(i)}] <= buf_valid[i] ? page_buf[i] : 16'hFFFF;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         buf_valid   <= '0;
         loading_reg <= 1'b0;
      end else if ((done && op_reg == op_write) ||
                   (fire && csr_reg[4:0] == `CMD_REEN)) begin
         buf_valid   <= '0;
         loading_reg <= 1'b0;
      end else if (ee_s2 && loading_reg) begin
         buf_valid   <= '0;
         loading_reg <= 1'b0;
      end else if (fire && csr_reg[4:0] == `CMD_LOAD) begin
         buf_valid[word_idx] <= 1'b1;
         loading_reg         <= 1'b1;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst)
         lock_reg <= `LOCK_RESET;
      else if (done && op_reg == op_lock)
         lock_reg <= lock_reg & bus.data_word[`LOCK_LSB+3:`LOCK_LSB];
   end

   // Byte read; lock readback refused while EEPROM busy
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rbyte_reg  <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= bus.byte_read;
         if (bus.byte_read && bus.pointer == `LOCK_PTR && !ee_s2)
            rbyte_reg <= {2'b11, lock_reg, 2'b11};
         else if (bus.byte_read)
            rbyte_reg <= bus.pointer[0] ? mem[bus.pointer[PW+PG:1]][15:8]
                                        : mem[bus.pointer[PW+PG:1]][7:0];
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst)
         irq_reg <= 1'b0;
      else
         irq_reg <= csr_reg[`CSR_IE_BIT] && !csr_reg[`CSR_EN_BIT];
   end

   assign bus.csr_rdata          = csr_reg;
   assign bus.read_byte          = rbyte_reg;
   assign bus.read_valid         = rvalid_reg;
   assign bus.cpu_stall          = stall_reg;
   assign bus.section_read_block = block_reg;
   assign bus.irq                = irq_reg;
   assign bus.reset_vector       = vec_reg;
endmodule
`default_nettype wire

// File: flash_sp_map.svh
// Notes on behaviour
// - Boot select fuse picks reset start address
// - Pointer splits into word and page fields
// - Target address latched at operation start
// - Byte reads use pointer bit zero
// - Erase: value X0000011 then store within four
// - Erase/write pointer holds page only, else zero
// - Concurrent-read target runs; halting target stalls CPU
// - Load: value 00000001 stores word at index
// - Buffer clears after write, re-enable, reset
// - Each buffer word loaded once per clear
// - EEPROM write during loading discards buffer
// - Write: value X0000101 programs buffer into page
// - Software masks interrupts around timed sequence
// - Interrupt asserted while enable bit clear
// - Erase/write blocks concurrent-read section reads
// - Busy flag held until re-enable write
// - Lock: value X0001001 ignores pointer
// - Zero data bits 5:2 program lock bits
// - Software sets pointer one, spare bits one
// - Lock programming never blocks or halts reads
// - EEPROM write blocks programming and lock reads
// - Software checks EEPROM busy before control write
// - Armed bits auto-clear after four cycles
`ifndef FLASH_SP_MAP_SVH
`define FLASH_SP_MAP_SVH
`define CSR_EN_BIT        0
`define CSR_ERASE_BIT     1
`define CSR_WRITE_BIT     2
`define CSR_LOCK_BIT      3
`define CSR_REEN_BIT      4
`define CSR_BUSY_BIT      6
`define CSR_IE_BIT        7
`define CMD_MASK          8'h1F
`define CMD_LOAD          8'h01
`define CMD_ERASE         8'h03
`define CMD_WRITE         8'h05
`define CMD_LOCK          8'h09
`define CMD_REEN          8'h11
`define ARM_WINDOW        3'h4
`define EE_QUIET          2'h2
`define LOCK_LSB          2
`define LOCK_RESET        4'hF
`define APP_RESET_ADDR    16'h0000
`define OP_TIME_US        4000
`define CLK_MHZ           50
`define LOCK_PTR          16'h0001
`define LOCK_SPARE_ONES   8'hC3
`endif

// File: flash_sp_pkg.sv
package flash_sp_pkg;
   typedef enum logic [1:0] {op_none, op_erase, op_write, op_lock} op_kind_t;
endpackage

// File: flash_sp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flash_sp_if;
   logic        csr_we;
   logic [7:0]  csr_wdata;
   logic [7:0]  csr_rdata;
   logic        store_exec;
   logic        byte_read;
   logic [15:0] pointer;
   logic [15:0] data_word;
   logic [7:0]  read_byte;
   logic        read_valid;
   logic        eeprom_write_busy;
   logic        cpu_stall;
   logic        section_read_block;
   logic        irq;
   logic [15:0] reset_vector;
   modport device (input csr_we, csr_wdata, store_exec, byte_read, pointer, data_word,
                   eeprom_write_busy,
                   output csr_rdata, read_byte, read_valid, cpu_stall, section_read_block,
                   irq, reset_vector);
   modport core (output csr_we, csr_wdata, store_exec, byte_read, pointer, data_word,
                 eeprom_write_busy,
                 input csr_rdata, read_byte, read_valid, cpu_stall, section_read_block,
                 irq, reset_vector);
endinterface
`default_nettype wire

// File: flash_sp_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_sp_map.svh"
module flash_sp_core
   import flash_sp_pkg::*;
(
   input  wire logic  clock,
   input  wire logic  sys_rst,
   input  wire logic  req_valid,
   input  wire logic [7:0]  req_cmd,
   input  wire logic [15:0] req_pointer,
   input  wire logic [15:0] req_data,
   input  wire logic  ee_busy,
   output logic       req_ready,
   output logic       req_done,
   flash_sp_if.core   bus
);
   typedef enum logic [2:0] {s_idle, s_wait_ee, s_arm, s_exec, s_poll} core_state_t;
   core_state_t st_reg;
   logic [7:0]  cmd_reg;
   logic [15:0] ptr_reg, data_reg;
   logic        we_reg, exec_reg, ready_reg, done_reg, ee_reg;
   logic [1:0]  quiet_reg;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= s_idle; cmd_reg <= 8'h00; ptr_reg <= 16'h0000; data_reg <= 16'h0000;
         we_reg <= 1'b0; exec_reg <= 1'b0; ready_reg <= 1'b0; done_reg <= 1'b0;
      end else begin
         we_reg <= 1'b0; exec_reg <= 1'b0; done_reg <= 1'b0;
         case (st_reg)
            s_idle: begin
               ready_reg <= 1'b1;
               if (req_valid && ready_reg) begin
                  ready_reg <= 1'b0;
                  cmd_reg   <= req_cmd;
                  // Lock write uses pointer one and spare data ones
                  ptr_reg   <= (req_cmd & `CMD_MASK) == `CMD_LOCK ? `LOCK_PTR
                                                                 : req_pointer;
                  data_reg  <= (req_cmd & `CMD_MASK) == `CMD_LOCK
                                  ? (req_data | 16'(`LOCK_SPARE_ONES))
                                                    : req_data;
                  st_reg    <= s_wait_ee;
               end
            end
            s_wait_ee: if (!ee_busy && quiet_reg >= `EE_QUIET &&
                           !bus.csr_rdata[`CSR_EN_BIT]) begin
               we_reg <= 1'b1;  // Interrupts assumed masked here by this sequencer
               st_reg <= s_arm;
            end
            s_arm: begin
               exec_reg <= 1'b1;
               st_reg   <= s_exec;
            end
            s_exec: st_reg <= s_poll;
            s_poll: if (!bus.csr_rdata[`CSR_EN_BIT]) begin
               done_reg <= 1'b1;
               st_reg   <= s_idle;
            end
            default: st_reg <= s_idle;
         endcase
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) ee_reg <= 1'b0;
      else         ee_reg <= ee_busy;
   end

   // Device resyncs busy through two more flops; a write before they settle is refused
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst)
         quiet_reg <= 2'h0;
      else if (ee_busy)
         quiet_reg <= 2'h0;
      else if (quiet_reg != 2'h3)
         quiet_reg <= quiet_reg + 2'h1;
   end

   assign bus.csr_we            = we_reg;
   assign bus.csr_wdata         = cmd_reg;
   assign bus.store_exec        = exec_reg;
   assign bus.byte_read         = 1'b0;
   assign bus.pointer           = ptr_reg;   // Caller must give page-only pointer for erase and write
   assign bus.data_word         = data_reg;  // Caller loads each word once per clear
   assign bus.eeprom_write_busy = ee_reg;
   assign req_ready             = ready_reg;
   assign req_done              = done_reg;
endmodule
`default_nettype wire

// File: flash_sp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module flash_sp_monitor #(
   parameter int HALT_PAGE_FIRST = 480,
   parameter int BOOT_ADDR       = 16'hF000
) (
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic        boot_reset_select,
   input wire logic        csr_we,
   input wire logic [7:0]  csr_wdata,
   input wire logic [7:0]  csr_rdata,
   input wire logic        store_exec,
   input wire logic        byte_read,
   input wire logic [15:0] pointer,
   input wire logic        read_valid,
   input wire logic        eeprom_write_busy,
   input wire logic        cpu_stall,
   input wire logic        section_read_block,
   input wire logic        irq,
   input wire logic [15:0] reset_vector
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Synced busy lags by two flops, so the start is only trusted after three quiet cycles
   sequence long_start;
      (!eeprom_write_busy)[*3] ##0
      (csr_we && (csr_wdata[4:0] == 5'h03 || csr_wdata[4:0] == 5'h05 || csr_wdata[4:0] == 5'h09))
      ##1 store_exec;
   endsequence
   sequence load_start;
      (!eeprom_write_busy)[*3] ##0 (csr_we && csr_wdata[4:0] == 5'h01) ##1 store_exec;
   endsequence
   chk_cmd_then_store: assert property (csr_we |=> store_exec)
      else $error("store did not follow control write");
   chk_enable_held: assert property (long_start |=> csr_rdata[0] [*8] ##[1:40] !csr_rdata[0])
      else $error("enable bit not held for the operation");
   chk_load_quick: assert property (load_start |=> ##[0:2] !csr_rdata[0])
      else $error("load did not finish promptly");
   chk_irq_level: assert property ((csr_rdata[7] && !csr_rdata[0]) [*2] |-> irq)
      else $error("interrupt missing while enable clear");
   chk_irq_quiet: assert property ((!csr_rdata[7] || csr_rdata[0]) [*2] |-> !irq)
      else $error("interrupt raised without cause");
   chk_vector_strap: assert property (!$past(sys_rst) |->
      reset_vector == (boot_reset_select ? 16'h0000 : BOOT_ADDR[15:0]))
      else $error("reset vector does not follow strap");
   chk_busy_clear: assert property ($fell(csr_rdata[6]) |->
      $past(store_exec) || $past(store_exec, 2))
      else $error("busy flag cleared without a store");
   chk_block_busy: assert property ((csr_rdata[0] && csr_rdata[6]) [*2] |-> section_read_block)
      else $error("section reads not blocked during operation");
   chk_halt_stall: assert property (store_exec && (csr_rdata[1] || csr_rdata[2]) &&
      pointer[15:8] >= HALT_PAGE_FIRST |-> ##[1:2] cpu_stall)
      else $error("halting page target did not stall");
   chk_lock_free: assert property (csr_rdata[3] && csr_rdata[0] |->
      !cpu_stall && !section_read_block)
      else $error("lock programming blocked reads");
   chk_read_reply: assert property (byte_read |=> read_valid)
      else $error("byte read not answered");
endmodule
`default_nettype wire

// File: flash_self_programming_controller_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module flash_self_programming_controller_tb_top;
   localparam int OPC  = 10;
   localparam int HALT = 200;
   localparam int BOOT = 16'hF000;
   logic        clock;
   logic        sys_rst;
   logic        boot_reset_select;
   logic        req_valid;
   logic [7:0]  req_cmd;
   logic [15:0] req_pointer;
   logic [15:0] req_data;
   logic        ee_busy;
   logic        req_ready;
   logic        req_done;
   logic [7:0]  seed;
   logic [7:0]  pages [2];
   logic        stall_seen;
   logic        block_seen;
   int          errors;
   int          samples_checked;
   int          took;
   flash_sp_if bus ();
   flash_sp_device #(.PAGES_LOG2(8), .HALT_PAGE_FIRST(HALT), .BOOT_ADDR(BOOT), .OP_CYCLES(OPC))
      flash_sp_device_inst (.clock(clock), .sys_rst(sys_rst),
                            .boot_reset_select(boot_reset_select), .bus(bus));
   flash_sp_core flash_sp_core_inst (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_pointer(req_pointer), .req_data(req_data), .ee_busy(ee_busy),
      .req_ready(req_ready), .req_done(req_done), .bus(bus));
   flash_sp_monitor #(.HALT_PAGE_FIRST(HALT), .BOOT_ADDR(BOOT)) flash_sp_monitor_inst (
      .clock(clock), .sys_rst(sys_rst), .boot_reset_select(boot_reset_select),
      .csr_we(bus.csr_we), .csr_wdata(bus.csr_wdata), .csr_rdata(bus.csr_rdata),
      .store_exec(bus.store_exec), .byte_read(bus.byte_read), .pointer(bus.pointer),
      .read_valid(bus.read_valid), .eeprom_write_busy(bus.eeprom_write_busy),
      .cpu_stall(bus.cpu_stall), .section_read_block(bus.section_read_block),
      .irq(bus.irq), .reset_vector(bus.reset_vector));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_flag(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask
   // One command through the core; the pointer is scrambled once taken
   task automatic issue(input logic [7:0] cmd, input logic [15:0] ptr, input logic [15:0] dat);
      int n;
      n = 0;
      stall_seen = 1'b0;
      block_seen = 1'b0;
      req_valid <= 1'b1;
      req_cmd <= cmd;
      req_pointer <= ptr;
      req_data <= dat;
      @(negedge clock);
      while (req_ready !== 1'b1 && n < 200) begin
         @(negedge clock);
         n++;
      end
      // Request held until the edge at which ready is sampled high
      @(posedge clock);
      seed = lfsr(seed);
      req_valid <= 1'b0;
      req_pointer <= {seed, ~seed};
      took = 0;
      @(negedge clock);
      while (req_done !== 1'b1 && took < 200) begin
         stall_seen |= (bus.cpu_stall === 1'b1);
         block_seen |= (bus.section_read_block === 1'b1);
         @(negedge clock);
         took++;
      end
      @(posedge clock);
      if (n >= 200 || took >= 200) begin
         errors++;
         $display("[ERR] handshake expected done seen timeout");
         tally_and_finish();
      end
   endtask
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      sys_rst = 1'b1;
      boot_reset_select = 1'b1;
      req_valid = 1'b0;
      req_cmd = 8'h00;
      req_pointer = 16'h0000;
      req_data = 16'h0000;
      ee_busy = 1'b0;
      seed = 8'h59;
      errors = 0;
      samples_checked = 0;
      pages = '{8'h05, 8'hDC};
      // Second pass is a mid-run reset with the strap flipped
      for (int s = 1; s >= 0; s--) begin
         boot_reset_select <= s[0];
         sys_rst <= 1'b1;
         repeat (2) @(posedge clock);
         sys_rst <= 1'b0;
         repeat (3) @(posedge clock);
         check_word("reset_vector", s[0] ? 16'h0000 : BOOT[15:0], bus.reset_vector);
         $display("test reset vector done");
      end
      foreach (pages[i]) begin
         issue(8'h03, {pages[i], 8'h00}, 16'hFFFF);
         check_flag("erase_long", 1'b1, took > OPC);
         check_flag("busy_flag", pages[i] < HALT, bus.csr_rdata[6]);
         check_flag("cpu_stall", pages[i] >= HALT, stall_seen);
         check_flag("read_block", 1'b1, block_seen);
         for (int w = 0; w < 4; w++) begin
            seed = lfsr(seed);
            issue(8'h01, {pages[i], seed[6:2], w[1:0], 1'b0}, {seed, ~seed});
            check_flag("load_quick", 1'b0, took > OPC);
         end
         ee_busy <= 1'b1;
         fork
            issue(8'h01, {pages[i], 8'h02}, 16'h1234);
            begin
               repeat (20) @(posedge clock);
               ee_busy <= 1'b0;
            end
         join
         check_flag("ee_refuse", 1'b1, took > 18);
         issue(8'h05, {pages[i], 8'h00}, 16'h0000);
         check_flag("write_long", 1'b1, took > OPC);
         issue(8'h11, 16'h0000, 16'h0000);
         check_flag("busy_clear", 1'b0, bus.csr_rdata[6]);
         $display("test page %0d done", i);
      end
      seed = lfsr(seed);
      issue(8'h89, 16'h0001, {8'hFF, 2'b11, seed[3:0], 2'b11});
      check_flag("lock_long", 1'b1, took > OPC);
      check_flag("lock_free", 1'b0, stall_seen | block_seen);
      repeat (2) @(posedge clock);
      check_flag("irq_on", 1'b1, bus.irq);
      issue(8'h11, 16'h0000, 16'h0000);
      repeat (2) @(posedge clock);
      check_flag("irq_off", 1'b0, bus.irq);
      $display("test lock and interrupt done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
